// *** pkg/frt_defines.vh ***
`ifndef FRT_DEFINES_VH
`define FRT_DEFINES_VH

// register byte addresses, one aligned word each
`define FRT_ADR_CONTROL_ONE 6'h00
`define FRT_ADR_CONTROL_TWO 6'h04
`define FRT_ADR_STATUS 6'h08
`define FRT_ADR_CMP1_HIGH 6'h0c
`define FRT_ADR_CMP1_LOW 6'h10
`define FRT_ADR_CMP2_HIGH 6'h14
`define FRT_ADR_CMP2_LOW 6'h18
`define FRT_ADR_COUNT_HIGH 6'h1c
`define FRT_ADR_COUNT_LOW 6'h20
`define FRT_ADR_ALT_HIGH 6'h24
`define FRT_ADR_ALT_LOW 6'h28
`define FRT_ADR_CONTROL_EXT 6'h2c

// control one fields
`define FRT_BIT_CMP_IRQ_EN 6
`define FRT_BIT_OVF_IRQ_EN 5
`define FRT_BIT_FORCE2 4
`define FRT_BIT_FORCE1 3
`define FRT_BIT_LEVEL2 2
`define FRT_BIT_LEVEL1 0
`define FRT_MASK_CONTROL_ONE 8'h7d

// control two fields
`define FRT_BIT_PIN_EN1 7
`define FRT_BIT_PIN_EN2 6
`define FRT_LSB_DIV_SEL 2
`define FRT_MASK_CONTROL_TWO 8'hcc

// control ext field
`define FRT_BIT_EXT_CLK 0

// status fields
`define FRT_BIT_CMP1_FLAG 6
`define FRT_BIT_OVF_FLAG 5
`define FRT_BIT_CMP2_FLAG 3

// divider select codes
`define FRT_DIV_BY4 2'h0
`define FRT_DIV_BY2 2'h1
`define FRT_DIV_BY8 2'h2

// reset, reload and wrap values
`define FRT_COUNT_RELOAD 16'hfffc
`define FRT_COUNT_TOP 16'hffff
`define FRT_CMP_RESET 16'h8000
`define FRT_CONTROL_RESET 8'h00

`endif

// *** design/frt_prescaler.v ***
`include "frt_defines.vh"
`default_nettype none

module frt_prescaler (
   // clock and reset
   input wire clk,
   input wire rst,
   // control
   input wire run,
   input wire [1:0] div_sel,
   input wire ext_sel,
   input wire ext_pin,
   // tick
   output reg tick
);

   reg [2:0] div_cnt;
   reg ext_meta;
   reg ext_sync;
   reg ext_last;
   reg next_tick;

   // external clock passes two flops, edge found past the second
   always @(posedge clk) begin
      if (rst) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_last <= 1'b0;
      end else begin
         ext_meta <= ext_pin;
         ext_sync <= ext_meta;
         ext_last <= ext_sync;
      end
   end

   always @* begin
      if (ext_sel) begin
         next_tick = ext_sync & ~ext_last;
      end else begin
         case (div_sel)
            `FRT_DIV_BY2: next_tick = (div_cnt[0] == 1'b1);
            `FRT_DIV_BY4: next_tick = (div_cnt[1:0] == 2'h3);
            `FRT_DIV_BY8: next_tick = (div_cnt == 3'h7);
            default: next_tick = 1'b0;
         endcase
      end
   end

   // halted divider freezes so counting resumes where it stopped
   always @(posedge clk) begin
      if (rst) begin
         div_cnt <= 3'h0;
         tick <= 1'b0;
      end else if (run) begin
         div_cnt <= div_cnt + 3'h1;
         tick <= next_tick;
      end else begin
         tick <= 1'b0;
      end
   end

endmodule // frt_prescaler

`default_nettype wire

// *** design/frt_compare.v ***
`include "frt_defines.vh"
`default_nettype none

module frt_compare (
   // clock and reset
   input wire clk,
   input wire rst,
   // bus side
   input wire wr_high,
   input wire wr_low,
   input wire acc_low,
   input wire status_read,
   input wire [7:0] wdata,
   // timer side
   input wire [15:0] count,
   input wire count_moved,
   input wire div2_mode,
   input wire level,
   input wire force_out,
   input wire pin_enable,
   // results
   output reg [15:0] compare_value,
   output reg compare_match_flag,
   output reg pin_latch
);

   reg inhibit;
   reg armed;
   wire [15:0] target;
   wire hit;

   // slower ticks see the match one count later
   assign target = div2_mode ? compare_value : compare_value + 16'h0001;
   assign hit = count_moved & ~inhibit & ~force_out & (count == target);

   always @(posedge clk) begin
      if (rst) begin
         compare_value <= `FRT_CMP_RESET;
         inhibit <= 1'b0;
      end else begin
         if (wr_high) begin
            compare_value[15:8] <= wdata;
            inhibit <= 1'b1;
         end
         if (wr_low) begin
            compare_value[7:0] <= wdata;
            inhibit <= 1'b0;
         end
      end
   end

   // set beats the second clearing step
   always @(posedge clk) begin
      if (rst) begin
         compare_match_flag <= 1'b0;
         armed <= 1'b0;
      end else begin
         if (hit) begin
            compare_match_flag <= 1'b1;
         end else if (acc_low & armed) begin
            compare_match_flag <= 1'b0;
         end
         if (status_read & compare_match_flag) begin
            armed <= 1'b1;
         end else if (acc_low) begin
            armed <= 1'b0;
         end
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         pin_latch <= 1'b0;
      end else if (pin_enable & force_out) begin
         pin_latch <= level;
      end else if (pin_enable & hit) begin
         pin_latch <= level;
      end
   end

endmodule // frt_compare

`default_nettype wire

// *** design/frt_timer.v ***
// Our own choices: the Wishbone register port and the address map.
`include "frt_defines.vh"
`default_nettype none

module frt_timer (
   // clock and reset
   input wire CLK_SYS,
   input wire SYS_RST,
   // wishbone slave
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [5:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   // cpu state
   input wire CPU_HALT,
   input wire CPU_IRQ_MASK,
   // pins
   input wire EXT_TIMER_CLK,
   output wire [1:0] COMPARE_OUTPUT_PIN,
   output wire [1:0] COMPARE_OUTPUT_PIN_OE,
   // interrupt request
   output wire TIMER_IRQ
);

   reg [7:0] timer_control_one;
   reg [7:0] timer_control_two;
   reg ext_clock_select;
   reg [15:0] main_count;
   reg overflow_flag;
   reg overflow_armed;
   reg [7:0] low_byte_buffer;
   reg read_pending;
   reg count_moved;

   wire take;
   wire rd;
   wire wr;
   wire wr_byte;
   wire tick;
   wire [1:0] tick_divider_select;
   wire div2_mode;
   wire status_read;
   wire [15:0] alt_count;
   wire [7:0] timer_status_reg;
   wire [1:0] compare_match_flag;
   wire [1:0] compare_pin_level;
   wire [1:0] force_compare_output;
   wire [1:0] compare_pin_enable;
   wire [1:0] cmp_wr_high;
   wire [1:0] cmp_wr_low;
   wire [1:0] cmp_acc_low;
   wire [15:0] compare_value [0:1];
   wire overflow_irq_enable;
   wire compare_irq_enable;
   wire high_read;
   wire low_read;
   wire main_low_access;
   wire reload;
   wire wrap;
   reg [7:0] next_rdata;

   // request taken once; ack follows one cycle later
   assign take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign rd = take & ~WB_WE_I;
   assign wr = take & WB_WE_I;
   assign wr_byte = wr & WB_SEL_I[0];

   assign tick_divider_select = timer_control_two[`FRT_LSB_DIV_SEL+1:`FRT_LSB_DIV_SEL];
   assign div2_mode = ~ext_clock_select & (tick_divider_select == `FRT_DIV_BY2);
   assign overflow_irq_enable = timer_control_one[`FRT_BIT_OVF_IRQ_EN];
   assign compare_irq_enable = timer_control_one[`FRT_BIT_CMP_IRQ_EN];
   assign compare_pin_level = {timer_control_one[`FRT_BIT_LEVEL2], timer_control_one[`FRT_BIT_LEVEL1]};
   assign force_compare_output = {timer_control_one[`FRT_BIT_FORCE2], timer_control_one[`FRT_BIT_FORCE1]};
   assign compare_pin_enable = {timer_control_two[`FRT_BIT_PIN_EN2], timer_control_two[`FRT_BIT_PIN_EN1]};

   assign status_read = rd & (WB_ADR_I == `FRT_ADR_STATUS);
   assign alt_count = main_count;
   assign high_read = rd & ((WB_ADR_I == `FRT_ADR_COUNT_HIGH) | (WB_ADR_I == `FRT_ADR_ALT_HIGH));
   assign low_read = rd & ((WB_ADR_I == `FRT_ADR_COUNT_LOW) | (WB_ADR_I == `FRT_ADR_ALT_LOW));
   // only the main view takes part in clearing the overflow flag
   assign main_low_access = take & (WB_ADR_I == `FRT_ADR_COUNT_LOW);
   assign reload = wr_byte & ((WB_ADR_I == `FRT_ADR_COUNT_LOW) | (WB_ADR_I == `FRT_ADR_ALT_LOW));
   assign wrap = tick & (main_count == `FRT_COUNT_TOP);

   assign cmp_wr_high = {wr_byte & (WB_ADR_I == `FRT_ADR_CMP2_HIGH), wr_byte & (WB_ADR_I == `FRT_ADR_CMP1_HIGH)};
   assign cmp_wr_low = {wr_byte & (WB_ADR_I == `FRT_ADR_CMP2_LOW), wr_byte & (WB_ADR_I == `FRT_ADR_CMP1_LOW)};
   assign cmp_acc_low = {take & (WB_ADR_I == `FRT_ADR_CMP2_LOW), take & (WB_ADR_I == `FRT_ADR_CMP1_LOW)};

   assign timer_status_reg = {1'b0, compare_match_flag[0], overflow_flag, 1'b0,
                              compare_match_flag[1], 3'h0};

   // halt stops the divider, wait has no effect on it
   frt_prescaler u_prescaler (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .run(~CPU_HALT),
      .div_sel(tick_divider_select),
      .ext_sel(ext_clock_select),
      .ext_pin(EXT_TIMER_CLK),
      .tick(tick)
   );

   // two compare channels
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_compare
         wire [15:0] value;
         frt_compare u_compare (
            .clk(CLK_SYS),
            .rst(SYS_RST),
            .wr_high(cmp_wr_high[ch]),
            .wr_low(cmp_wr_low[ch]),
            .acc_low(cmp_acc_low[ch]),
            .status_read(status_read),
            .wdata(WB_DAT_I[7:0]),
            .count(main_count),
            .count_moved(count_moved),
            .div2_mode(div2_mode),
            .level(compare_pin_level[ch]),
            .force_out(force_compare_output[ch]),
            .pin_enable(compare_pin_enable[ch]),
            .compare_value(value),
            .compare_match_flag(compare_match_flag[ch]),
            .pin_latch(COMPARE_OUTPUT_PIN[ch])
         );
         assign compare_value[ch] = value;
         // pin left to general-purpose use while disabled
         assign COMPARE_OUTPUT_PIN_OE[ch] = compare_pin_enable[ch];
      end
   endgenerate

   // control registers
   always @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         timer_control_one <= `FRT_CONTROL_RESET;
         timer_control_two <= `FRT_CONTROL_RESET;
         ext_clock_select <= 1'b0;
      end else if (wr_byte) begin
         case (WB_ADR_I)
            `FRT_ADR_CONTROL_ONE: begin
               timer_control_one <= WB_DAT_I[7:0] & `FRT_MASK_CONTROL_ONE;
            end
            `FRT_ADR_CONTROL_TWO: begin
               timer_control_two <= WB_DAT_I[7:0] & `FRT_MASK_CONTROL_TWO;
            end
            `FRT_ADR_CONTROL_EXT: begin
               ext_clock_select <= WB_DAT_I[`FRT_BIT_EXT_CLK];
            end
            default: begin
            end
         endcase
      end
   end

   // free-running counter; reload wins over a tick in the same cycle
   always @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         main_count <= `FRT_COUNT_RELOAD;
         count_moved <= 1'b0;
      end else begin
         if (reload) begin
            main_count <= `FRT_COUNT_RELOAD;
         end else if (tick) begin
            main_count <= main_count + 16'h0001;
         end
         count_moved <= tick | reload;
      end
   end

   // overflow flag: a wrap in the clearing cycle is kept
   always @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         overflow_flag <= 1'b0;
         overflow_armed <= 1'b0;
      end else begin
         if (wrap) begin
            overflow_flag <= 1'b1;
         end else if (main_low_access & overflow_armed) begin
            overflow_flag <= 1'b0;
         end
         if (status_read & overflow_flag) begin
            overflow_armed <= 1'b1;
         end else if (main_low_access) begin
            overflow_armed <= 1'b0;
         end
      end
   end

   // one-byte read buffer for the low count byte, shared by both count views
   always @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         low_byte_buffer <= 8'h00;
         read_pending <= 1'b0;
      end else begin
         if (high_read & ~read_pending) begin
            low_byte_buffer <= main_count[7:0];
            read_pending <= 1'b1;
         end else if (low_read) begin
            read_pending <= 1'b0;
         end
      end
   end

   // read mux; unmapped addresses read zero
   always @* begin
      case (WB_ADR_I)
         `FRT_ADR_CONTROL_ONE: next_rdata = timer_control_one;
         `FRT_ADR_CONTROL_TWO: next_rdata = timer_control_two;
         `FRT_ADR_CONTROL_EXT: next_rdata = {7'h00, ext_clock_select};
         `FRT_ADR_STATUS: next_rdata = timer_status_reg;
         `FRT_ADR_CMP1_HIGH: next_rdata = compare_value[0][15:8];
         `FRT_ADR_CMP1_LOW: next_rdata = compare_value[0][7:0];
         `FRT_ADR_CMP2_HIGH: next_rdata = compare_value[1][15:8];
         `FRT_ADR_CMP2_LOW: next_rdata = compare_value[1][7:0];
         `FRT_ADR_COUNT_HIGH: next_rdata = main_count[15:8];
         `FRT_ADR_ALT_HIGH: next_rdata = alt_count[15:8];
         `FRT_ADR_COUNT_LOW: next_rdata = read_pending ? low_byte_buffer : main_count[7:0];
         `FRT_ADR_ALT_LOW: next_rdata = read_pending ? low_byte_buffer : alt_count[7:0];
         default: next_rdata = 8'h00;
      endcase
   end

   // bus answer
   always @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= take;
         if (rd) begin
            WB_DAT_O <= {24'h000000, next_rdata};
         end
      end
   end

   // flags stay pending until the mask and enables allow them
   assign TIMER_IRQ = ~CPU_IRQ_MASK & ((overflow_flag & overflow_irq_enable) |
                      (|compare_match_flag & compare_irq_enable));

endmodule // frt_timer

`default_nettype wire

// *** test/frt_timer_monitor.sv ***
`include "frt_defines.vh"
`default_nettype none

module frt_timer_monitor (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   // register bus
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [5:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // cpu, pins, request
   input wire logic CPU_IRQ_MASK,
   input wire logic [1:0] COMPARE_OUTPUT_PIN,
   input wire logic [1:0] COMPARE_OUTPUT_PIN_OE,
   input wire logic TIMER_IRQ
);
   timeunit 1ns;
   timeprecision 1ns;
   logic take;
   logic rd_ack;
   logic [7:0] cmp1_high;
   assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign rd_ack = WB_ACK_O && !WB_WE_I;
   // hardware never alters compare values, so a shadow of the writes predicts reads
   always @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cmp1_high <= 8'h80;
      end else if (take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `FRT_ADR_CMP1_HIGH) begin
         cmp1_high <= WB_DAT_I[7:0];
      end
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   AST_ACK_PULSE: assert property (take |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("ack not a single pulse one cycle after request");
   AST_IRQ_MASKED: assert property (CPU_IRQ_MASK |-> !TIMER_IRQ)
      else $error("interrupt requested while masked");
   AST_IRQ_FALL: assert property ($fell(TIMER_IRQ) |-> CPU_IRQ_MASK || WB_ACK_O)
      else $error("interrupt dropped without mask or bus access");
   AST_PIN_RESET: assert property ($fell(SYS_RST) |-> COMPARE_OUTPUT_PIN == 2'b00 && COMPARE_OUTPUT_PIN_OE == 2'b00)
      else $error("pins not low after reset");
   AST_RELOAD: assert property ((WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `FRT_ADR_COUNT_LOW) ##1 !WB_CYC_I
      ##1 (take && !WB_WE_I && WB_ADR_I == `FRT_ADR_COUNT_HIGH) |=> WB_DAT_O[7:0] == 8'hff)
      else $error("count high not ff right after reload");
   AST_CMP_HOLD: assert property (rd_ack && WB_ADR_I == `FRT_ADR_CMP1_HIGH |-> WB_DAT_O == {24'h0, cmp1_high})
      else $error("compare high differs from last written value");
   AST_STATUS_RSV: assert property (rd_ack && WB_ADR_I == `FRT_ADR_STATUS |-> (WB_DAT_O & 32'hffffff97) == 32'h0)
      else $error("status reads a bit outside the three flags");
   AST_PIN_EN: assert property (rd_ack && WB_ADR_I == `FRT_ADR_CONTROL_TWO
      |-> WB_DAT_O[7:6] == {COMPARE_OUTPUT_PIN_OE[0], COMPARE_OUTPUT_PIN_OE[1]})
      else $error("pin enable bits and output enables disagree");
endmodule // frt_timer_monitor

bind frt_timer frt_timer_monitor i_frt_timer_monitor (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CPU_IRQ_MASK(CPU_IRQ_MASK), .COMPARE_OUTPUT_PIN(COMPARE_OUTPUT_PIN),
   .COMPARE_OUTPUT_PIN_OE(COMPARE_OUTPUT_PIN_OE), .TIMER_IRQ(TIMER_IRQ));
`default_nettype wire

// *** test/frt_timer_test.sv ***
`include "frt_defines.vh"
`default_nettype none

module frt_timer_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, sys_rst, cyc, stb, we, halt, irq_mask, ext_clk, ack, irq;
   logic [5:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_i, dat_o;
   logic [1:0] pin, pin_oe;
   logic [7:0] q;
   logic [7:0] ticks [4] = '{8'd10, 8'd20, 8'd5, 8'd0};
   int n_mismatch, n_tests;

   frt_timer i_frt_timer (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CPU_HALT(halt),
      .CPU_IRQ_MASK(irq_mask), .EXT_TIMER_CLK(ext_clk), .COMPARE_OUTPUT_PIN(pin),
      .COMPARE_OUTPUT_PIN_OE(pin_oe), .TIMER_IRQ(irq));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         n_mismatch++;
      end
   endtask

   // one classic cycle; bounded wait so a silent slave cannot hang the run
   task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         chk(1'b0, 1'b1, "ack timeout");
         conclude();
      end
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e, input string what);
      wb(1'b0, a, 8'h00);
      chk(q, e, what);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   initial begin
      sys_rst = 1'b1;
      {cyc, stb, we, halt, irq_mask, ext_clk} = 6'h00;
      adr = 6'h00;
      sel = 4'h1;
      dat_i = 32'h0;
      n_mismatch = 0;
      n_tests = 0;
      idle(16);
      sys_rst <= 1'b0;
      rd(`FRT_ADR_COUNT_HIGH, 8'hff, "count high");
      wb(1'b0, `FRT_ADR_COUNT_LOW, 8'h00);
      rd(`FRT_ADR_CONTROL_ONE, 8'h00, "control one");
      rd(`FRT_ADR_CONTROL_TWO, 8'h00, "control two");
      rd(`FRT_ADR_STATUS, 8'h00, "status");
      rd(`FRT_ADR_CMP1_HIGH, 8'h80, "cmp1 high");
      rd(`FRT_ADR_CMP1_LOW, 8'h00, "cmp1 low");
      rd(`FRT_ADR_CMP2_HIGH, 8'h80, "cmp2 high");
      wb(1'b1, 6'h30, 8'hff);
      rd(6'h30, 8'h00, "unmapped");
      $display("test reset values done");
      // halt freezes the count so each window of 40 cycles is measured alone
      for (int i = 0; i < 4; i++) begin
         halt <= 1'b1;
         wb(1'b1, `FRT_ADR_CONTROL_TWO, 8'(i << 2));
         wb(1'b1, `FRT_ADR_COUNT_LOW, 8'h00);
         halt <= 1'b0;
         idle(40);
         halt <= 1'b1;
         idle(2);
         wb(1'b0, `FRT_ADR_COUNT_HIGH, 8'h00);
         wb(1'b0, `FRT_ADR_COUNT_LOW, 8'h00);
         chk(8'(q - 8'hfc - ticks[i] + 8'h01) <= 8'h02, 1'b1, "ticks");
      end
      $display("test prescaler done");
      wb(1'b1, `FRT_ADR_COUNT_LOW, 8'h00);
      rd(`FRT_ADR_COUNT_HIGH, 8'hff, "reload high");
      idle(40);
      rd(`FRT_ADR_COUNT_HIGH, 8'hff, "halted high");
      halt <= 1'b0;
      wb(1'b1, `FRT_ADR_CONTROL_TWO, 8'h08);
      idle(60);
      wb(1'b0, `FRT_ADR_ALT_HIGH, 8'h00);
      rd(`FRT_ADR_ALT_LOW, 8'hfc, "buffered low");
      wb(1'b0, `FRT_ADR_COUNT_LOW, 8'h00);
      chk(q == 8'hfc, 1'b0, "live low");
      $display("test read sequence done");
      rd(`FRT_ADR_STATUS, 8'h20, "overflow");
      chk(irq, 1'b0, "irq off");
      wb(1'b1, `FRT_ADR_CONTROL_ONE, 8'h20);
      chk(irq, 1'b1, "irq on");
      irq_mask <= 1'b1;
      idle(2);
      chk(irq, 1'b0, "irq masked");
      irq_mask <= 1'b0;
      idle(2);
      chk(irq, 1'b1, "irq pending");
      wb(1'b0, `FRT_ADR_ALT_LOW, 8'h00);
      rd(`FRT_ADR_STATUS, 8'h20, "alt keeps flag");
      wb(1'b0, `FRT_ADR_COUNT_LOW, 8'h00);
      rd(`FRT_ADR_STATUS, 8'h00, "flag cleared");
      chk(irq, 1'b0, "irq cleared");
      $display("test overflow done");
      wb(1'b1, `FRT_ADR_CONTROL_TWO, 8'hc4);
      chk(pin_oe, 2'b11, "pins enabled");
      wb(1'b1, `FRT_ADR_CONTROL_ONE, 8'h41);
      wb(1'b1, `FRT_ADR_CMP1_HIGH, 8'h00);
      wb(1'b1, `FRT_ADR_CMP1_LOW, 8'h05);
      wb(1'b1, `FRT_ADR_COUNT_LOW, 8'h00);
      idle(40);
      chk(pin, 2'b01, "pin level");
      rd(`FRT_ADR_STATUS, 8'h60, "cmp1 flag");
      chk(irq, 1'b1, "cmp irq");
      rd(`FRT_ADR_CMP1_LOW, 8'h05, "cmp1 low");
      rd(`FRT_ADR_STATUS, 8'h20, "cmp1 cleared");
      chk(irq, 1'b0, "cmp irq off");
      wb(1'b1, `FRT_ADR_CMP2_HIGH, 8'h00);
      wb(1'b1, `FRT_ADR_COUNT_LOW, 8'h00);
      idle(40);
      // channel one still live and matches again after the reload
      rd(`FRT_ADR_STATUS, 8'h60, "inhibited");
      wb(1'b1, `FRT_ADR_CMP2_LOW, 8'h30);
      wb(1'b1, `FRT_ADR_COUNT_LOW, 8'h00);
      idle(150);
      rd(`FRT_ADR_STATUS, 8'h68, "cmp2 flag");
      chk(pin, 2'b01, "level two low");
      rd(`FRT_ADR_CMP2_LOW, 8'h30, "cmp2 low");
      rd(`FRT_ADR_CMP1_LOW, 8'h05, "cmp1 low again");
      $display("test compare done");
      wb(1'b1, `FRT_ADR_CONTROL_ONE, 8'h18);
      idle(4);
      chk(pin, 2'b00, "forced low");
      wb(1'b1, `FRT_ADR_CONTROL_ONE, 8'h1d);
      idle(4);
      chk(pin, 2'b11, "forced high");
      wb(1'b1, `FRT_ADR_COUNT_LOW, 8'h00);
      idle(150);
      rd(`FRT_ADR_STATUS, 8'h20, "force no flag");
      wb(1'b1, `FRT_ADR_CONTROL_TWO, 8'h04);
      chk(pin_oe, 2'b00, "pins off");
      wb(1'b1, `FRT_ADR_CONTROL_ONE, 8'h40);
      wb(1'b1, `FRT_ADR_COUNT_LOW, 8'h00);
      idle(150);
      rd(`FRT_ADR_STATUS, 8'h68, "flags no pins");
      $display("test force and pin enable done");
      wb(1'b1, `FRT_ADR_CONTROL_EXT, 8'h01);
      wb(1'b1, `FRT_ADR_COUNT_LOW, 8'h00);
      repeat (6) begin
         ext_clk <= 1'b1;
         idle(4);
         ext_clk <= 1'b0;
         idle(4);
      end
      idle(6);
      rd(`FRT_ADR_COUNT_HIGH, 8'h00, "ext high");
      rd(`FRT_ADR_COUNT_LOW, 8'h02, "ext low");
      $display("test external clock done");
      conclude();
   end
endmodule // frt_timer_test
`default_nettype wire
